// file: logic/dgea_pkg.sv
// Purpose: constants and types for the dma run control and channel pointers
// Assumes: 32-bit classic wishbone register access, byte addresses
// Notes:   two channels, one register window of four words per channel
package dgea_pkg;
   localparam int          NCH        = 2;
   localparam logic [7:0]  GCFG_OFF   = 8'h00;
   localparam logic [3:0]  CH_PAGE0   = 4'h1;
   localparam logic [1:0]  SRC_IDX    = 2'h0;
   localparam logic [1:0]  DST_IDX    = 2'h1;
   localparam logic [1:0]  SETUP_IDX  = 2'h2;
   localparam logic [1:0]  CNT_IDX    = 2'h3;
   localparam int          GCFG_RUN   = 0;
   localparam int          GCFG_MBIT  = 1;
   localparam int          SET_EN     = 0;
   localparam int          SET_SSZ    = 1;
   localparam int          SET_DSZ    = 4;
   localparam int          SET_FAULT  = 9;
   localparam logic [2:0]  SZ_BYTE    = 3'h0;
   localparam logic [2:0]  SZ_HALF    = 3'h1;
   localparam logic [2:0]  SZ_WORD    = 3'h2;
   localparam logic [31:0] PTR_RESET  = 32'h0000_0000;
   localparam logic [15:0] CNT_RESET  = 16'h0000;

   typedef enum logic [1:0] {
      DGEA_IDLE = 2'b01,
      DGEA_BUSY = 2'b10
   } dgea_st_t;

   typedef struct packed {
      dgea_st_t                 st;
      logic                     run;
      logic                     mbit;
      logic [NCH-1:0]           en;
      logic [NCH-1:0]           fault;
      logic [NCH-1:0][2:0]      ssz;
      logic [NCH-1:0][2:0]      dsz;
      logic [NCH-1:0][31:0]     src;
      logic [NCH-1:0][31:0]     dst;
      logic [NCH-1:0][15:0]     cnt;
      logic                     act;
      logic                     ack;
      logic [31:0]              dat;
      logic                     req;
      logic [31:0]              msrc;
      logic [31:0]              mdst;
      logic [2:0]               mssz;
      logic [2:0]               mdsz;
   } dgea_state_t;
endpackage

// file: logic/dgea_top.sv
// Purpose: global run control, per-channel source and target pointers
// Assumes: one clock, synchronous reset, mem_done_i from same-clock logic
// Notes:   one item is moved at a time, lowest enabled channel first
//
// The register addresses and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dgea_top
   import dgea_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   input  wire logic        mem_done_i,
   output logic             mem_req_o,
   output logic [31:0]      mem_src_o,
   output logic [31:0]      mem_dst_o,
   output logic [2:0]       mem_ssz_o,
   output logic [2:0]       mem_dsz_o,
   output logic             mem_chan_o
);
   import dgea_pkg::*;

   dgea_state_t s_q;
   dgea_state_t s_d;

   // reserved size codes advance as bytes
   function automatic logic [31:0] step(input logic [2:0] sz);
      logic [31:0] r;
      r = 32'h0000_0001;
      if (sz == SZ_HALF) r = 32'h0000_0002;
      if (sz == SZ_WORD) r = 32'h0000_0004;
      return r;
   endfunction

   // alignment is judged once, when enable is written
   function automatic logic misal(input logic [2:0] sz,
                                  input logic [31:0] a);
      logic r;
      r = 1'b0;
      if (sz == SZ_HALF) r = a[0];
      if (sz == SZ_WORD) r = |a[1:0];
      return r;
   endfunction

   // byte-lane merge for partial writes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   logic        req_new;
   logic        is_gcfg;
   logic        ch_hit;
   logic        ch;
   logic [1:0]  ridx;
   logic [31:0] wv;
   logic        pick;
   logic        found;

   always_comb begin
      s_d     = s_q;
      req_new = cyc_i && stb_i && !s_q.ack;
      is_gcfg = (adr_i == GCFG_OFF);
      // two pages only; other addresses except GCFG_OFF read zero
      ch_hit  = (adr_i[7:4] == CH_PAGE0) ||
                (adr_i[7:4] == CH_PAGE0 + 4'h1);
      ch      = adr_i[4] ^ CH_PAGE0[0];
      ridx    = adr_i[3:2];
      wv      = 32'h0000_0000;
      pick    = 1'b0;
      found   = 1'b0;
      // answer drops the cycle after it was given
      s_d.ack = req_new;
      s_d.dat = 32'h0000_0000;
      if (req_new) begin
         if (is_gcfg) begin
            s_d.dat[GCFG_RUN]  = s_q.run;
            s_d.dat[GCFG_MBIT] = s_q.mbit;
            if (we_i && sel_i[0]) begin
               s_d.run  = dat_i[GCFG_RUN];
               s_d.mbit = dat_i[GCFG_MBIT];
            end
         end else if (ch_hit && s_q.run) begin
            unique case (ridx)
               SRC_IDX: begin
                  s_d.dat = s_q.src[ch];
                  if (we_i && !s_q.en[ch])
                     s_d.src[ch] = merge(s_q.src[ch], dat_i, sel_i);
               end
               DST_IDX: begin
                  s_d.dat = s_q.dst[ch];
                  if (we_i && !s_q.en[ch])
                     s_d.dst[ch] = merge(s_q.dst[ch], dat_i, sel_i);
               end
               SETUP_IDX: begin
                  s_d.dat[SET_EN]              = s_q.en[ch];
                  s_d.dat[SET_SSZ +: 3]        = s_q.ssz[ch];
                  s_d.dat[SET_DSZ +: 3]        = s_q.dsz[ch];
                  s_d.dat[SET_FAULT]           = s_q.fault[ch];
                  if (we_i) begin
                     wv = merge(s_d.dat, dat_i, sel_i);
                     // sizes stay writable while enabled; software keeps them
                     // item size codes
                     s_d.ssz[ch] = wv[SET_SSZ +: 3];
                     s_d.dsz[ch] = wv[SET_DSZ +: 3];
                     if (sel_i[1] && dat_i[SET_FAULT])
                        s_d.fault[ch] = 1'b0;
                     if (wv[SET_EN] && !s_q.en[ch] &&
                         (misal(wv[SET_SSZ +: 3], s_q.src[ch]) ||
                          misal(wv[SET_DSZ +: 3], s_q.dst[ch])))
                        // misaligned start refused, flag set wins
                        s_d.fault[ch] = 1'b1;
                     else
                        s_d.en[ch] = wv[SET_EN];
                  end
               end
               CNT_IDX: begin
                  s_d.dat[15:0] = s_q.cnt[ch];
                  // count is 16 bits; upper lanes are dropped on purpose
                  if (we_i && !s_q.en[ch]) begin
                     wv = merge({16'h0000, s_q.cnt[ch]}, dat_i, sel_i);
                     s_d.cnt[ch] = wv[15:0];
                  end
               end
            endcase
         end
      end

      unique case (s_q.st)
         DGEA_IDLE: begin
            // fixed priority: channel 1 may wait behind channel 0
            for (int c = NCH - 1; c >= 0; c--) begin
               if (s_q.en[c]) begin
                  found = 1'b1;
                  pick  = c[0];
               end
            end
            if (found && s_q.run) begin
               if (s_q.cnt[pick] == CNT_RESET) begin
                  // nothing left: channel switches itself off
                  s_d.en[pick] = 1'b0;
               end else begin
                  s_d.act  = pick;
                  s_d.req  = 1'b1;
                  s_d.msrc = s_q.src[pick];
                  s_d.mdst = s_q.dst[pick];
                  s_d.mssz = s_q.ssz[pick];
                  s_d.mdsz = s_q.dsz[pick];
                  s_d.st   = DGEA_BUSY;
               end
            end
         end
         DGEA_BUSY: begin
            // an item in flight always completes, even if stopped
            if (mem_done_i) begin
               s_d.req = 1'b0;
               s_d.src[s_q.act] = s_q.src[s_q.act] + step(s_q.mssz);
               s_d.dst[s_q.act] = s_q.dst[s_q.act] + step(s_q.mdsz);
               s_d.cnt[s_q.act] = s_q.cnt[s_q.act] - 16'h0001;
               if (s_q.cnt[s_q.act] == 16'h0001)
                  s_d.en[s_q.act] = 1'b0;
               s_d.st = DGEA_IDLE;
            end
         end
      endcase
   end

   // reset overrides ce_i so a frozen block can still be cleared
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q       <= '0;
         s_q.st    <= DGEA_IDLE;
         s_q.src   <= {NCH{PTR_RESET}};
         s_q.dst   <= {NCH{PTR_RESET}};
         s_q.cnt   <= {NCH{CNT_RESET}};
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // outputs come straight from the state register
   assign dat_o      = s_q.dat;
   assign ack_o      = s_q.ack;
   assign mem_req_o  = s_q.req;
   assign mem_src_o  = s_q.msrc;
   assign mem_dst_o  = s_q.mdst;
   assign mem_ssz_o  = s_q.mssz;
   assign mem_dsz_o  = s_q.mdsz;
   assign mem_chan_o = s_q.act;
endmodule
`default_nettype wire

// file: verif/dgea_asserts.sv
// Purpose: port assertions for the dma run control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every dgea_top instance
`timescale 1ns/1ps
`default_nettype none
module dgea_asserts
   import dgea_pkg::*;
(
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        ce_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   input wire logic [31:0] dat_o,
   input wire logic        mem_done_i,
   input wire logic        mem_req_o,
   input wire logic [31:0] mem_src_o,
   input wire logic [31:0] mem_dst_o,
   input wire logic [2:0]  mem_ssz_o,
   input wire logic [2:0]  mem_dsz_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_taken;
      cyc_i && stb_i && !ack_o && ce_i;
   endsequence
   sequence s_item_moved;
      mem_req_o && mem_done_i && ce_i;
   endsequence
   a_ack_next_cycle: assert property (s_taken |=> ack_o)
      else $error("request not acknowledged");
   a_ack_one_pulse: assert property (ack_o && ce_i |=> !ack_o)
      else $error("ack held too long");
   a_data_quiet: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_req_holds: assert property (mem_req_o && !mem_done_i && ce_i
      |=> mem_req_o && $stable(mem_src_o) && $stable(mem_dst_o))
      else $error("item request dropped early");
   a_req_retires: assert property (s_item_moved |=> !mem_req_o)
      else $error("request kept after done");
   a_src_aligned: assert property (mem_req_o |->
      (mem_ssz_o != SZ_HALF || !mem_src_o[0]) &&
      (mem_ssz_o != SZ_WORD || mem_src_o[1:0] == 2'h0))
      else $error("misaligned source item");
   a_dst_aligned: assert property (mem_req_o |->
      (mem_dsz_o != SZ_HALF || !mem_dst_o[0]) &&
      (mem_dsz_o != SZ_WORD || mem_dst_o[1:0] == 2'h0))
      else $error("misaligned target item");
   a_reset_idle: assert property ($past(rst_i) |-> !ack_o &&
      !mem_req_o && mem_src_o == 32'h0 && mem_dst_o == 32'h0)
      else $error("outputs not idle after reset");
endmodule
bind dgea_top dgea_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
   .dat_o(dat_o), .mem_done_i(mem_done_i), .mem_req_o(mem_req_o),
   .mem_src_o(mem_src_o), .mem_dst_o(mem_dst_o),
   .mem_ssz_o(mem_ssz_o), .mem_dsz_o(mem_dsz_o));
`default_nettype wire

// file: verif/dgea_mem_model.sv
// Purpose: system bus memory answering item requests
// Assumes: same clock as the dma block
// Notes:   lat_i sets the wait; 0 answers promptly
`timescale 1ns/1ps
`default_nettype none
module dgea_mem_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       req_i,
   input  wire logic [3:0] lat_i,
   output logic            done_o
);
   logic [3:0] wait_q;
   // one pulse per request, never while idle
   always_ff @(posedge clk_i) begin
      if (rst_i || !req_i || done_o) begin
         wait_q <= 4'h0;
         done_o <= 1'b0;
      end else begin
         wait_q <= wait_q + 4'h1;
         done_o <= (wait_q == lat_i);
      end
   end
endmodule
`default_nettype wire

// file: verif/test_dma_global_enable_and_channel_addresses.sv
// Purpose: register-level tests of run control and channel pointers
// Assumes: 50 MHz clock, classic wishbone single cycles
// Notes:   sel_i tied active; lanes are not the subject here
`timescale 1ns/1ps
`default_nettype none
module test_dma_global_enable_and_channel_addresses;
   import dgea_pkg::*;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [7:0]  c;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd;
   logic [31:0] rdat;
   logic        ack;
   logic        req;
   logic        done;
   logic [3:0]  lat = 4'h0;
   logic        ce = 1'b1;
   logic        chan;
   logic [2:0]  ssz;
   int          fails = 0;
   int          checks_done = 0;
   int          k;
   always #10 clk_i = ~clk_i;
   dgea_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
      .dat_o(rdat), .ack_o(ack), .mem_done_i(done), .mem_req_o(req),
      .mem_src_o(), .mem_dst_o(), .mem_ssz_o(ssz), .mem_dsz_o(),
      .mem_chan_o(chan));
   dgea_mem_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
      .lat_i(lat), .done_o(done));
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fails++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // hang guard, far beyond the fewer than two hundred cycles needed
   initial begin
      repeat (5000) @(posedge clk_i);
      fails++;
      report_and_stop();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b1, 8'h10, 32'h0000_1234);
      rchk(8'h10, 32'h0);
      rchk(GCFG_OFF, 32'h0);
      bus(1'b1, GCFG_OFF, 32'h0000_0001);
      rchk(GCFG_OFF, 32'h1);
      rchk(8'h10, 32'h0);
      rchk(8'h14, 32'h0);
      rchk(8'hF0, 32'h0);
      // byte, half and word size codes, both channels, slow memory after the first
      for (k = 0; k < 3; k++) begin
         c = (k == 1) ? 8'h20 : 8'h10;
         lat <= 4'(k * 3);
         bus(1'b1, c, 32'h0000_0100);
         bus(1'b1, c + 8'h4, 32'h0000_0200);
         bus(1'b1, c + 8'hC, 32'h3);
         bus(1'b1, c + 8'h8, 32'(1 + (k << 1) + ((2 - k) << 4)));
         do bus(1'b0, c + 8'h8, 32'h0); while (rd[0] !== 1'b0);
         chk({31'h0, chan}, 32'(k == 1));
         chk({29'h0, ssz}, 32'(k));
         rchk(c, 32'(32'h100 + 3 * (1 << k)));
         rchk(c + 8'h4, 32'(32'h200 + 3 * (1 << (2 - k))));
      end
      bus(1'b1, 8'h10, 32'h0000_0101);
      bus(1'b1, 8'h18, 32'h3);
      rchk(8'h10, 32'h0000_0101);
      bus(1'b0, 8'h18, 32'h0);
      chk(rd & 32'h201, 32'h200);
      bus(1'b1, 8'h18, 32'h0000_0200);
      rchk(8'h18, 32'h0);
      // frozen by ce: the request waits until ce returns
      ce <= 1'b0;
      fork
         bus(1'b0, GCFG_OFF, 32'h0);
         begin
            repeat (4) @(posedge clk_i);
            chk({31'h0, ack}, 32'h0);
            ce <= 1'b1;
         end
      join
      chk(rd, 32'h1);
      bus(1'b1, GCFG_OFF, 32'h0);
      rchk(8'h10, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
